// ### src/ret_stack_pkg.sv
// shared constants for the return address stack block
// assumes a single instruction clock and a 12-bit program address space
package ret_stack_pkg;

	localparam int unsigned pc_width_full  = 12;
	localparam int unsigned pc_width_small = 11;
	localparam int unsigned stack_levels   = 8;
	localparam int unsigned short_levels   = 2;
	localparam int unsigned page_hi        = 11;
	localparam int unsigned page_lo        = 9;
	localparam int unsigned page_width     = 3;
	localparam int unsigned data_width     = 8;
	localparam int unsigned status_page_lo = 5;

	localparam logic [11:0] stack_reset_value = 12'h000;
	localparam logic [7:0]  data_reset_value  = 8'h00;

	// one-hot operation select from the sequencer
	typedef enum logic [5:0] {
		op_none    = 6'h01,
		op_call    = 6'h02,
		op_plain_return   = 6'h04,
		op_page_return    = 6'h08,
		op_literal_return = 6'h10,
		op_irq_return     = 6'h20
	} op_type;

endpackage

// ### src/return_address_stack.sv
// return address stack and return-instruction datapath
// assumes the sequencer presents one decoded operation per enabled cycle
`timescale 1ns/100ps
// What this block does
// (R01) any subroutine return loads the whole pc from the top entry, page bits ignored
// (R02) plain return alters only pc and stack contents
// (R03) page-restoring return also copies popped address bits 11:9 into page select
// (R04) literal return also loads the working accumulator with the instruction literal
// (R05) interrupt return restores pc, w, status, file select from shadows; stack untouched
// (R06) interrupt return with adjust also adds w into the real-time counter
// (R07) stack is an eight entry lifo, 12 bits, or 11 on the small variant
// (R08) small variant depth is two by default, eight when extend bit set
// (R09) a call pushes the address of the instruction after the call
// (R10) on call all entries shift down, old bottom entry discarded
// (R11) on return entries shift up, bottom entry keeps its value
// (R12) stack is a shift chain with no pointer register
// (R13) entries are not data-mapped; only calls and returns reach them
// (R14) software must not overflow the stack nor return without a call
// (R15) at depth two only the top two entries shift, second acts as bottom
module return_address_stack
	import ret_stack_pkg::*;
#(
	parameter int unsigned pc_width     = pc_width_full,
	parameter int unsigned levels       = stack_levels,
	parameter bit          small_device = 1'b0
) (
	// clock and reset
	input  wire logic                clock,
	input  wire logic                rstn,
	input  wire logic                clock_en,
	// configuration
	input  wire logic                stack_depth_extend,
	// operation from the sequencer
	input  wire logic                op_valid,
	input  wire logic [5:0]          op_sel,
	input  wire logic                op_adjust,
	input  wire logic [7:0]          literal,
	// current core state
	input  wire logic [pc_width-1:0] pc_now,
	input  wire logic [7:0]          w_now,
	input  wire logic [7:0]          real_time_counter,
	// interrupt-time shadow copies
	input  wire logic [pc_width-1:0] shadow_pc,
	input  wire logic [7:0]          shadow_w,
	input  wire logic [7:0]          shadow_status,
	input  wire logic [7:0]          shadow_file_select_pointer,
	// program counter load
	output logic                     pc_load,
	output logic [pc_width-1:0]      pc_value,
	// working accumulator load
	output logic                     w_load,
	output logic [7:0]               w_value,
	// status load, full or page bits only
	output logic                     status_load,
	output logic                     page_select_load,
	output logic [7:0]               status_value,
	output logic [2:0]               page_select_bits,
	// file select pointer load
	output logic                     file_select_load,
	output logic [7:0]               file_select_pointer,
	// real-time counter load
	output logic                     rtc_load,
	output logic [7:0]               rtc_value,
	// visible top of stack for debug
	output logic [pc_width-1:0]      stack_top
);

	logic [pc_width-1:0] stack_q [levels];
	logic [pc_width-1:0] stack_d [levels];
	logic                take;
	logic                do_call;
	logic                do_pop;
	logic                do_page_return;
	logic                do_literal_return;
	logic                do_irq_return;
	logic                do_adjust;
	logic                short_mode;
	logic [pc_width-1:0] top_entry;
	logic [pc_width-1:0] return_address;

	// one-hot decode helpers shared by the stack chain and the load logic
	function automatic logic is_call(input logic [5:0] sel);
		is_call = (sel == op_call);
	endfunction

	function automatic logic is_sub_return(input logic [5:0] sel);
		is_sub_return = (sel == op_plain_return) || (sel == op_page_return) || (sel == op_literal_return);
	endfunction

	function automatic logic is_irq_return(input logic [5:0] sel);
		is_irq_return = (sel == op_irq_return);
	endfunction

	// page field of a return address; a narrow pc reads zero in the missing top bit
	function automatic logic [page_width-1:0] page_of(input logic [pc_width-1:0] addr);
		logic [pc_width_full-1:0] wide;
		wide    = pc_width_full'(addr);
		page_of = wide[page_hi:page_lo];
	endfunction

	// an op counts only in an enabled cycle; anything not one-hot is a no-op
	assign take              = clock_en && op_valid;
	assign do_call           = take && is_call(op_sel);
	assign do_pop            = take && is_sub_return(op_sel);
	assign do_page_return    = take && (op_sel == op_page_return);
	assign do_literal_return = take && (op_sel == op_literal_return);
	assign do_irq_return     = take && is_irq_return(op_sel);
	assign do_adjust         = do_irq_return && op_adjust;
	assign short_mode        = small_device && !stack_depth_extend; // [R08]
	assign top_entry         = stack_q[0];
	// cut on purpose: the return address wraps at the top of program memory
	assign return_address    = pc_width'(pc_now + 1'b1); // [R09]
	assign stack_top         = top_entry;

	// shifting chain with no pointer; the levels in use all move on one edge, deeper ones idle at depth two [R12] [R07]
	// entries are internal only; only the top entry is readable, on stack_top, and there is no write port into them [R13]
	generate
		for (genvar i = 0; i < levels; i++) begin : g_level
			// neighbours clamped so the end levels never index outside the chain
			localparam int above        = (i == 0) ? 0 : i - 1;
			localparam int below        = (i == levels - 1) ? i : i + 1;
			localparam bit beyond_short = (i >= short_levels);
			localparam bit short_bottom = (i == short_levels - 1);

			always_comb begin
				stack_d[i] = stack_q[i];
				if (short_mode && beyond_short) begin
					stack_d[i] = stack_q[i]; // deeper levels idle at depth two [R15]
				end else if (do_call) begin
					if (i == 0) begin
						stack_d[i] = return_address; // [R09]
					end else begin
						stack_d[i] = stack_q[above]; // old bottom falls off [R10]
					end
				end else if (do_pop) begin
					if (i == levels - 1) begin
						stack_d[i] = stack_q[i]; // bottom keeps its value [R11]
					end else if (short_mode && short_bottom) begin
						stack_d[i] = stack_q[i]; // level 1 is the bottom at depth two [R15]
					end else begin
						stack_d[i] = stack_q[below]; // [R11]
					end
				end
			end

			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					stack_q[i] <= stack_reset_value[pc_width-1:0];
				end else if (clock_en) begin
					stack_q[i] <= stack_d[i];
				end
			end
		end
	endgenerate

	// program counter load
	// flags hold while clock_en is low, so a frozen core sees a steady request
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pc_load <= 1'b0;
		end else if (clock_en) begin
			pc_load <= do_pop || do_irq_return; // [R01] [R05]
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pc_value <= stack_reset_value[pc_width-1:0];
		end else if (take) begin
			case (op_sel)
				op_plain_return, op_page_return, op_literal_return: begin
					pc_value <= top_entry; // full address, page bits not consulted [R01]
				end
				op_irq_return: begin
					pc_value <= shadow_pc; // [R05]
				end
				default: begin
					pc_value <= pc_value;
				end
			endcase
		end
	end

	// working accumulator; a plain return raises none of the loads below [R02]
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			w_load <= 1'b0;
		end else if (clock_en) begin
			w_load <= do_literal_return || do_irq_return; // [R04] [R05]
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			w_value <= data_reset_value;
		end else if (take) begin
			case (op_sel)
				op_literal_return: begin
					w_value <= literal; // [R04]
				end
				op_irq_return: begin
					w_value <= shadow_w; // [R05]
				end
				default: begin
					w_value <= w_value;
				end
			endcase
		end
	end

	// status register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			status_load <= 1'b0;
		end else if (clock_en) begin
			status_load <= do_irq_return; // [R05]
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			status_value <= data_reset_value;
		end else if (take) begin
			case (op_sel)
				op_irq_return: begin
					status_value <= shadow_status; // [R05]
				end
				default: begin
					status_value <= status_value;
				end
			endcase
		end
	end

	// page select bits; an interrupt return refreshes them through the full status load
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			page_select_load <= 1'b0;
		end else if (clock_en) begin
			page_select_load <= do_page_return; // [R03]
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			page_select_bits <= '0;
		end else if (take) begin
			case (op_sel)
				op_page_return: begin
					page_select_bits <= page_of(top_entry); // bits 11:9 of the popped address [R03]
				end
				op_irq_return: begin
					page_select_bits <= shadow_status[status_page_lo +: page_width]; // [R05]
				end
				default: begin
					page_select_bits <= page_select_bits;
				end
			endcase
		end
	end

	// file select pointer
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			file_select_load <= 1'b0;
		end else if (clock_en) begin
			file_select_load <= do_irq_return; // [R05]
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			file_select_pointer <= data_reset_value;
		end else if (take) begin
			case (op_sel)
				op_irq_return: begin
					file_select_pointer <= shadow_file_select_pointer; // [R05]
				end
				default: begin
					file_select_pointer <= file_select_pointer;
				end
			endcase
		end
	end

	// real-time counter; the adjust uses w as it stood before the restore
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rtc_load <= 1'b0;
		end else if (clock_en) begin
			rtc_load <= do_adjust; // [R06]
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rtc_value <= data_reset_value;
		end else if (do_adjust) begin
			rtc_value <= 8'(real_time_counter + w_now); // sum wraps like the counter [R06]
		end
	end

endmodule // return_address_stack

// ### tb/ras_checker_asserts.sv
// port assertions for return_address_stack
// binds onto every instance; widths follow its pc_width
`timescale 1ns/100ps
module ras_checker #(parameter int unsigned pc_width = 12) (
	input wire logic                clock, rstn, clock_en, op_valid, op_adjust,
	input wire logic [5:0]          op_sel,
	input wire logic [7:0]          literal, w_now, real_time_counter, shadow_w, shadow_status,
	input wire logic [7:0]          shadow_file_select_pointer, w_value, status_value, file_select_pointer, rtc_value,
	input wire logic [pc_width-1:0] pc_now, shadow_pc, pc_value, stack_top,
	input wire logic                pc_load, w_load, status_load, page_select_load, file_select_load, rtc_load,
	input wire logic [2:0]          page_select_bits
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	wire go = clock_en && op_valid;
	wire rt = op_sel == 6'h04 || op_sel == 6'h08 || op_sel == 6'h10;
	a_call_push: assert property (go && op_sel == 6'h02 |=> stack_top == $past(pc_now) + 1'b1) else $error("push");
	a_return_pc: assert property (go && rt |=> pc_load && pc_value == $past(stack_top)) else $error("return pc");
	a_plain_quiet: assert property (go && op_sel == 6'h04 |=> !(w_load || status_load || page_select_load
		|| file_select_load || rtc_load)) else $error("plain return side effect");
	a_page_copy: assert property (go && op_sel == 6'h08 |=> page_select_load
		&& page_select_bits == 3'($past(stack_top) >> 9)) else $error("page bits");
	a_lit_load: assert property (go && op_sel == 6'h10 |=> w_load && w_value == $past(literal)) else $error("lit");
	a_irq_restore: assert property (go && op_sel == 6'h20 |=> pc_load && file_select_load && pc_value == $past(shadow_pc)
		&& w_value == $past(shadow_w) && status_value == $past(shadow_status) && stack_top == $past(stack_top)
		&& file_select_pointer == $past(shadow_file_select_pointer)) else $error("interrupt return");
	a_rtc_adjust: assert property (go && op_sel == 6'h20 && op_adjust |=> rtc_load
		&& rtc_value == 8'($past(real_time_counter) + $past(w_now))) else $error("adjust");
	a_idle_hold: assert property (clock_en && !op_valid |=> !pc_load && !w_load && $stable(stack_top)) else $error("idle");
	a_freeze_hold: assert property (!clock_en |=> $stable(stack_top) && $stable(pc_load) && $stable(pc_value)) else $error("freeze");
endmodule // ras_checker
bind return_address_stack ras_checker #(.pc_width(pc_width)) u_chk (.*);

// ### tb/core_model.sv
// far-side core model: accumulator and free-running real-time counter
// assumes one-cycle load pulses from the stack block
`timescale 1ns/100ps
module core_model (
	input wire logic       clock, rstn, w_load, rtc_load,
	input wire logic [7:0] w_value, rtc_value,
	output logic [7:0]     w_q, rtc_q
);
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) w_q <= 8'h5a;
		else if (w_load) w_q <= w_value;
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) rtc_q <= 8'h00;
		else if (rtc_load) rtc_q <= rtc_value;
		else rtc_q <= rtc_q + 8'h01;
	end
endmodule // core_model

// ### tb/test_return_address_stack.sv
// bench: nesting, overflow, extra pops, interrupt returns, refused ops
// assumes core_model on the far side and the bound checker
`timescale 1ns/100ps
module test_return_address_stack;
	logic        clock = 0, rstn = 0, op_valid = 0, op_adjust = 0, pc_load, w_load, rtc_load;
	logic        clock_en = 1, ext = 0, pc_load2;
	logic [10:0] pc_value2, top2, stk2[$], pc2_exp[$];
	logic [11:0] top;
	logic [7:0]  rtc_exp[$];
	logic [5:0]  op_sel = 6'h01;
	logic [7:0]  literal = 0, sw = 0, ss = 0, sf = 0, w_now, rtc, w_value, rtc_value;
	logic [11:0] pc_now = 0, spc = 0, pc_value, stk[$], pc_exp[$];
	logic [7:0]  w_exp[$];
	int          error_cnt = 0, num_checks = 0, seed = 40, i;
	initial forever #4 clock = ~clock;
	return_address_stack DUT (.clock(clock), .rstn(rstn), .clock_en(clock_en), .stack_depth_extend(ext),
		.op_valid(op_valid), .op_sel(op_sel), .op_adjust(op_adjust), .literal(literal), .pc_now(pc_now),
		.w_now(w_now), .real_time_counter(rtc), .shadow_pc(spc), .shadow_w(sw), .shadow_status(ss),
		.shadow_file_select_pointer(sf), .pc_load(pc_load), .pc_value(pc_value), .w_load(w_load),
		.w_value(w_value), .status_load(), .page_select_load(), .status_value(), .page_select_bits(),
		.file_select_load(), .file_select_pointer(), .rtc_load(rtc_load), .rtc_value(rtc_value), .stack_top(top));
	return_address_stack #(.pc_width(11), .small_device(1'b1)) DUT_small (.clock(clock), .rstn(rstn),
		.clock_en(clock_en), .stack_depth_extend(ext), .op_valid(op_valid), .op_sel(op_sel), .op_adjust(op_adjust),
		.literal(literal), .pc_now(pc_now[10:0]), .w_now(w_now), .real_time_counter(rtc), .shadow_pc(spc[10:0]),
		.shadow_w(sw), .shadow_status(ss), .shadow_file_select_pointer(sf), .pc_load(pc_load2),
		.pc_value(pc_value2), .w_load(), .w_value(), .status_load(), .page_select_load(), .status_value(),
		.page_select_bits(), .file_select_load(), .file_select_pointer(), .rtc_load(), .rtc_value(),
		.stack_top(top2));
	core_model u_core (.clock(clock), .rstn(rstn), .w_load(w_load), .rtc_load(rtc_load), .w_value(w_value),
		.rtc_value(rtc_value), .w_q(w_now), .rtc_q(rtc));
	task automatic cmp(input string n, input logic [11:0] e, s);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic op(input logic [5:0] s, input logic adj);
		op_valid = 1;
		op_sel = s;
		op_adjust = adj;
		{pc_now, literal, spc, sw, ss, sf} = {$random(seed), $random(seed)};
		if (s == 6'h02) begin
			stk.push_front(pc_now + 12'h1);
			void'(stk.pop_back());
			stk2.push_front(pc_now[10:0] + 11'h1);
			if (stk2.size() > (ext ? 8 : 2)) void'(stk2.pop_back());
		end else if (s == 6'h20) begin
			pc_exp.push_back(spc);
			pc2_exp.push_back(spc[10:0]);
			w_exp.push_back(sw);
			if (adj) rtc_exp.push_back(rtc + w_now);
		end else if (s == 6'h04 || s == 6'h08 || s == 6'h10) begin
			pc_exp.push_back(stk.pop_front());
			stk.push_back(stk[6]);
			pc2_exp.push_back(stk2.pop_front());
			stk2.push_back(stk2[$]);
			if (s == 6'h10) w_exp.push_back(literal);
		end
		@(posedge clock);
		#1;
	endtask
	// sampled mid-cycle so the load pulses have settled
	always @(negedge clock) if (rstn) begin
		if (pc_load === 1'b1) cmp("pc_value", pc_exp.pop_front(), pc_value);
		if (w_load === 1'b1) cmp("w_value", {4'h0, w_exp.pop_front()}, {4'h0, w_value});
		if (pc_load2 === 1'b1) cmp("small pc_value", {1'b0, pc2_exp.pop_front()}, {1'b0, pc_value2});
		if (rtc_load === 1'b1) cmp("rtc_value", {4'h0, rtc_exp.pop_front()}, {4'h0, rtc_value});
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#5000;
		error_cnt++;
		tally_and_finish;
	end
	initial begin
		repeat (8) stk.push_back(12'h000);
		repeat (2) stk2.push_back(11'h000);
		repeat (20) @(posedge clock);
		#1 rstn = 1;
		for (i = 0; i < 8; i++) op(6'h02, 0);
		for (i = 0; i < 9; i++) op(6'h04 << (i % 3), 0);
		$display("nesting test done");
		for (i = 0; i < 11; i++) op(6'h02, 0);
		for (i = 0; i < 8; i++) op(6'h04 << (i % 3), 0);
		$display("overflow test done");
		ext = 1; // deeper levels of the small instance still hold their reset value
		repeat (6) stk2.push_back(11'h000);
		for (i = 0; i < 5; i++) op(6'h02, 0);
		for (i = 0; i < 5; i++) op(6'h04 << (i % 3), 0);
		$display("extended depth test done");
		for (i = 0; i < 4; i++) op(6'h20, i[0]);
		op(6'h01, 0);
		op(6'h06, 0);
		op(6'h04, 0);
		op_valid = 0;
		@(posedge clock);
		#1 clock_en = 0;
		op_valid = 1;
		op_sel = 6'h02;
		repeat (3) @(posedge clock);
		#1 cmp("stack_top", stk[0], top);
		cmp("small stack_top", {1'b0, stk2[0]}, {1'b0, top2});
		clock_en = 1;
		op_valid = 0;
		repeat (3) @(posedge clock);
		$display("interrupt return test done");
		tally_and_finish;
	end
endmodule // test_return_address_stack
